// *** hw/dma_prio_pkg.sv ***
package dma_prio_pkg;

  localparam int NUM_CHANNELS = 4;
  localparam int COUNT_WIDTH = 16;
  localparam int ADDR_WIDTH = 4;
  localparam int DATA_WIDTH = 16;

  // register offsets on the command port
  localparam logic [3:0] CTRL_BASE = 4'h0;   // channel control, one per channel
  localparam logic [3:0] COUNT_BASE = 4'h4;  // byte count, one per channel
  localparam logic [3:0] PRIORITY_OFFSET = 4'h8;

  // channel control fields
  localparam int CTRL_BURST_BIT = 0;
  localparam int CTRL_STRETCH_BIT = 1;
  localparam int CTRL_BUSY_BIT = 6;
  localparam int CTRL_BLOCK_END_BIT = 7;

  // priority control fields
  localparam int PRIO_ENABLE_LSB = 0;
  localparam int PRIO_ROTATE_BIT = 7;

  // values after reset, and byte count constants
  localparam logic [1:0] LAST_SERVICED_RESET = 2'h3;
  localparam logic [3:0] ENABLE_RESET = 4'h0;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] COUNT_ONE = 16'h0001;

  // cycles spent between two services
  localparam int DEAD_CYCLES = 1;
  localparam int RELEASE_CYCLES = 1;

  typedef struct packed {
    logic [ADDR_WIDTH-1:0] addr;
    logic [DATA_WIDTH-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic burst;
    logic stretch;
  } chan_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_GRANT,
    ST_XFER,
    ST_WAIT,
    ST_DEAD,
    ST_RELEASE
  } dma_state_t;

endpackage

// *** hw/dma_channel_priority_status.sv ***
// How it works
// - A channel request reaches the selector only while its enable bit is 1.
// - A channel whose zero flag is 0 has its request ignored.
// - Cycle steal keeps the latched channel until its one byte is done.
// - Burst keeps the latched channel until its byte count hits zero.
// - Latched channel stays even if request drops; transfer waits for request high.
// - The executing channel's request is refused while a service runs.
// - Normal priority: channel 0 highest, then 1, 2, 3.
// - Rotate priority: channel after last serviced first, last serviced lowest.
// - After reset rotation starts as if channel 3 was served last.
// - A lower channel waits for the higher one to finish, then starts.
// - Halt to halt channel change: one dead cycle, halt request stays low.
// - Stretch to stretch channel change: bus goes back for two cycles.
// - Same channel halt cycle steal: bus released between two bytes.
// - Same channel stretch: processor gets two clocks after each byte.
// - Busy, block end and zero flags per channel; zero flag not readable.
// - Busy set when the channel is first latched into grant, cleared when block ends at zero count.
// - Block end set at zero count, cleared right after control register read.
// - Zero flag set on nonzero count write, cleared at zero count or zero write.
// - Reset clears zero flag but keeps byte count; software must rewrite count.
//
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none

module dma_channel_priority_status (
  input wire logic clock,                                   // system clock, 50 MHz
  input wire logic rst_n,                                   // synchronous reset, active low
  input wire logic ce,                                      // clock enable, freezes all state when low
  input wire dma_prio_pkg::reg_req_t reg_req,               // register command port
  output logic [dma_prio_pkg::DATA_WIDTH-1:0] reg_rdata,    // read data, cycle after the read strobe
  input wire logic [dma_prio_pkg::NUM_CHANNELS-1:0] channel_transfer_request, // request pins
  input wire logic bus_grant,                               // processor gave up the bus, pin
  output logic halt_bus_request_n,                          // halt mode bus request, active low
  output logic stretch_bus_request_n,                       // clock stretch bus request, active low
  output logic transfer_ack,                                // a channel holds the bus side
  output logic transfer_strobe,                             // one byte moves this cycle
  output logic [1:0] exec_channel                           // latched executing channel
);
  import dma_prio_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pick the winning channel; base is where the search starts
  function automatic logic [2:0] pick(input logic [3:0] req, input logic [1:0] base);
    logic [2:0] res;
    logic [1:0] idx;
    res = 3'h0;
    for (int i = NUM_CHANNELS - 1; i >= 0; i--) begin
      idx = base + 2'(i);
      if (req[idx]) begin
        res = {1'b1, idx};
      end
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state
  dma_state_t state;
  dma_state_t next_state;
  logic [3:0] req_meta;
  logic [3:0] req_sync;
  logic grant_meta;
  logic grant_sync;
  logic [3:0] enable;
  logic rotate;
  logic [1:0] last_serviced;
  chan_mode_t mode [NUM_CHANNELS];
  logic [COUNT_WIDTH-1:0] byte_count [NUM_CHANNELS];
  logic [3:0] busy;
  logic [3:0] block_end;
  logic [3:0] zero_flag;
  logic [1:0] cur;
  logic [1:0] next_cur;

  ////////////////////////////////////////////////////////////////////////////
  // pins come from outside the clock domain: two flops before any use
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      req_meta <= 4'h0;
      req_sync <= 4'h0;
      grant_meta <= 1'b0;
      grant_sync <= 1'b0;
    end else if (ce) begin
      req_meta <= channel_transfer_request;
      req_sync <= req_meta;
      grant_meta <= bus_grant;
      grant_sync <= grant_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register decode
  wire is_ctrl = reg_req.addr[3:2] == CTRL_BASE[3:2];
  wire is_count = reg_req.addr[3:2] == COUNT_BASE[3:2];
  wire is_prio = reg_req.addr == PRIORITY_OFFSET;
  wire [1:0] sel_ch = reg_req.addr[1:0];
  wire ctrl_wr = reg_req.wr && is_ctrl;
  wire count_wr = reg_req.wr && is_count;
  wire prio_wr = reg_req.wr && is_prio;
  wire ctrl_rd = reg_req.rd && is_ctrl;
  wire count_wr_zero = reg_req.wdata == COUNT_ZERO;

  ////////////////////////////////////////////////////////////////////////////
  // selection: enabled, armed, and not the channel already in service
  wire [3:0] cur_onehot = 4'h1 << cur;
  wire [3:0] armed = enable & zero_flag;
  wire [3:0] refuse = (state == ST_IDLE) ? 4'h0 : cur_onehot;
  wire [3:0] eligible = req_sync & armed & ~refuse;
  wire [1:0] search_base = rotate ? last_serviced + 2'h1 : 2'h0;
  wire [2:0] winner = pick(eligible, search_base);
  wire win_valid = winner[2];
  wire [1:0] win_ch = winner[1:0];
  wire cur_stretch = mode[cur].stretch;
  wire cur_burst = mode[cur].burst && !mode[cur].stretch;   // stretch mode has no burst
  wire win_stretch = mode[win_ch].stretch;
  wire last_byte = byte_count[cur] == COUNT_ONE;
  wire cur_armed = armed[cur];
  // a halt to halt change keeps the bus, anything else hands it back first
  wire halt_to_halt = win_valid && !cur_stretch && !win_stretch;
  wire service_end = state == ST_XFER && (!cur_burst || last_byte);

  ////////////////////////////////////////////////////////////////////////////
  // sequencer next state
  always_comb begin
    next_state = state;
    next_cur = cur;
    case (state)
      ST_IDLE: begin
        if (win_valid) begin
          next_state = ST_GRANT;
          next_cur = win_ch;
        end
      end
      ST_GRANT: begin
        if (!cur_armed) begin
          next_state = ST_RELEASE;
        end else if (grant_sync && req_sync[cur]) begin
          next_state = ST_XFER;
        end
      end
      ST_XFER: begin
        if (!service_end) begin
          next_state = ST_WAIT;
        end else if (halt_to_halt) begin
          next_state = ST_DEAD;
          next_cur = win_ch;
        end else begin
          next_state = ST_RELEASE;
        end
      end
      ST_WAIT: begin
        if (!cur_armed) begin
          next_state = ST_RELEASE;
        end else if (req_sync[cur]) begin
          next_state = ST_XFER;
        end
      end
      ST_DEAD: begin
        next_state = ST_GRANT;
      end
      ST_RELEASE: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer flops and the latched channel
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      cur <= 2'h0;
    end else if (ce) begin
      state <= next_state;
      cur <= next_cur;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // rotation pointer moves only when a service ends
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      last_serviced <= LAST_SERVICED_RESET;
    end else if (ce && service_end) begin
      last_serviced <= cur;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software control: enables, rotate, channel modes
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      enable <= ENABLE_RESET;
      rotate <= 1'b0;
      for (int c = 0; c < NUM_CHANNELS; c++) begin
        mode[c] <= '0;
      end
    end else if (ce) begin
      if (prio_wr) begin
        enable <= reg_req.wdata[PRIO_ENABLE_LSB +: NUM_CHANNELS];
        rotate <= reg_req.wdata[PRIO_ROTATE_BIT];
      end
      if (ctrl_wr) begin
        mode[sel_ch].burst <= reg_req.wdata[CTRL_BURST_BIT];
        mode[sel_ch].stretch <= reg_req.wdata[CTRL_STRETCH_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // byte count has no reset on purpose: its contents survive reset
  always_ff @(posedge clock) begin
    if (ce) begin
      if (count_wr) begin
        byte_count[sel_ch] <= reg_req.wdata;
      end
      if (state == ST_XFER && !(count_wr && sel_ch == cur)) begin
        byte_count[cur] <= byte_count[cur] - COUNT_ONE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status flags per channel; a hardware set beats a same-cycle clear
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      busy <= 4'h0;
      block_end <= 4'h0;
      zero_flag <= 4'h0;
    end else if (ce) begin
      for (int c = 0; c < NUM_CHANNELS; c++) begin
        // zero flag: a software write decides over the count running out
        if (count_wr && sel_ch == 2'(c)) begin
          zero_flag[c] <= !count_wr_zero;
        end else if (state == ST_XFER && cur == 2'(c) && last_byte) begin
          zero_flag[c] <= 1'b0;
        end
        if (state == ST_XFER && cur == 2'(c) && last_byte) begin
          busy[c] <= 1'b0;
        end else if (next_state == ST_GRANT && state != ST_GRANT && next_cur == 2'(c)) begin
          busy[c] <= 1'b1;
        end
        if (state == ST_XFER && cur == 2'(c) && last_byte) begin
          block_end[c] <= 1'b1;
        end else if (ctrl_rd && sel_ch == 2'(c)) begin
          block_end[c] <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux; zero flag never appears, unmapped reads return zero
  logic [DATA_WIDTH-1:0] read_value;
  always_comb begin
    read_value = '0;
    if (is_ctrl) begin
      read_value[CTRL_BURST_BIT] = mode[sel_ch].burst;
      read_value[CTRL_STRETCH_BIT] = mode[sel_ch].stretch;
      read_value[CTRL_BUSY_BIT] = busy[sel_ch];
      read_value[CTRL_BLOCK_END_BIT] = block_end[sel_ch];
    end else if (is_count) begin
      read_value = byte_count[sel_ch];
    end else if (is_prio) begin
      read_value[PRIO_ENABLE_LSB +: NUM_CHANNELS] = enable;
      read_value[PRIO_ROTATE_BIT] = rotate;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (ce) begin
      reg_rdata <= reg_req.rd ? read_value : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus side outputs; the dead cycle keeps the halt request asserted
  wire holding = state == ST_GRANT || state == ST_XFER || state == ST_WAIT || state == ST_DEAD;
  assign halt_bus_request_n = !(holding && !cur_stretch);
  assign stretch_bus_request_n = !(holding && cur_stretch && state != ST_DEAD);
  assign transfer_ack = holding;
  assign transfer_strobe = state == ST_XFER;
  assign exec_channel = cur;

endmodule // dma_channel_priority_status

`default_nettype wire

// *** verification/dma_prio_properties.sv ***
`timescale 1ns/1ns
`default_nettype none
module dma_prio_properties (
  input wire logic clock, // system clock
  input wire logic rst_n, // sync reset, active low
  input wire logic ce, // clock enable
  input wire dma_prio_pkg::reg_req_t reg_req, // command port
  input wire logic [dma_prio_pkg::DATA_WIDTH-1:0] reg_rdata, // read data
  input wire logic [dma_prio_pkg::NUM_CHANNELS-1:0] channel_transfer_request, // request pins
  input wire logic bus_grant, // processor off the bus
  input wire logic halt_bus_request_n, // halt request
  input wire logic stretch_bus_request_n, // stretch request
  input wire logic transfer_ack, // channel holds bus side
  input wire logic transfer_strobe, // byte moves
  input wire logic [1:0] exec_channel // latched channel
);
  import dma_prio_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic [3:0] en_q;
  logic [3:0] burst_q;
  // shadow of enables and burst bits, so the checks know what software asked for
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      en_q <= ENABLE_RESET;
      burst_q <= 4'h0;
    end else if (reg_req.wr) begin
      if (reg_req.addr == PRIORITY_OFFSET) en_q <= reg_req.wdata[3:0];
      if (reg_req.addr < COUNT_BASE) burst_q[reg_req.addr[1:0]] <= reg_req.wdata[CTRL_BURST_BIT];
    end
  end
  sequence halt_byte;
    transfer_strobe && !halt_bus_request_n;
  endsequence
  sequence channel_switch;
    !halt_bus_request_n && exec_channel != $past(exec_channel);
  endsequence
  a_strobe_single: assert property (transfer_strobe |=> !transfer_strobe)
    else $error("strobe longer than one cycle");
  a_strobe_acked: assert property (transfer_strobe |-> transfer_ack)
    else $error("strobe without acknowledge");
  a_exec_fixed: assert property (transfer_strobe |-> $stable(exec_channel))
    else $error("channel moved before its byte");
  a_masked_chan: assert property (transfer_strobe |-> en_q[exec_channel])
    else $error("disabled channel served");
  a_one_request: assert property (transfer_ack |-> halt_bus_request_n != stretch_bus_request_n)
    else $error("bus request lines disagree with ack");
  a_stretch_back: assert property (transfer_strobe && !stretch_bus_request_n |=>
    stretch_bus_request_n && !transfer_ack) else $error("stretch bus not returned");
  a_halt_dead: assert property (halt_byte ##1 channel_switch |=>
    !halt_bus_request_n && transfer_ack && !transfer_strobe) else $error("halt switch not one dead cycle");
  a_steal_release: assert property (halt_byte and !burst_q[exec_channel] |=>
    halt_bus_request_n || exec_channel != $past(exec_channel)) else $error("halt steal kept bus");
  a_rdata_idle: assert property (!$past(reg_req.rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside its cycle");
  // two reads of one control register with a gap between them, and no byte moved meanwhile
  a_end_clears: assert property (reg_req.rd && reg_req.addr < COUNT_BASE && !transfer_strobe ##1
    !transfer_strobe ##1 reg_req.rd && reg_req.addr == $past(reg_req.addr, 2) && !transfer_strobe
    |=> !reg_rdata[CTRL_BLOCK_END_BIT])
    else $error("block end survived a read");
endmodule // dma_prio_properties
bind dma_channel_priority_status dma_prio_properties u_props (.clock(clock), .rst_n(rst_n), .ce(ce),
  .reg_req(reg_req), .reg_rdata(reg_rdata), .channel_transfer_request(channel_transfer_request),
  .bus_grant(bus_grant), .halt_bus_request_n(halt_bus_request_n), .stretch_bus_request_n(stretch_bus_request_n),
  .transfer_ack(transfer_ack), .transfer_strobe(transfer_strobe), .exec_channel(exec_channel));
`default_nettype wire

// *** verification/req_partner.sv ***
`timescale 1ns/1ns
`default_nettype none
module req_partner (
  input wire logic clock, // system clock
  input wire logic halt_bus_request_n, // halt request
  input wire logic stretch_bus_request_n, // stretch request
  input wire logic transfer_strobe, // byte moved
  input wire logic [1:0] exec_channel, // served channel
  output logic [dma_prio_pkg::NUM_CHANNELS-1:0] channel_transfer_request, // request pins
  output logic bus_grant // processor off the bus
);
  import dma_prio_pkg::*;
  int want [NUM_CHANNELS] = '{default: 0};
  int grant_delay = 1;
  int wait_cnt = 0;
  initial bus_grant = 1'b0;
  // bytes a peripheral still has to move; added between edges, counted down at the rising edge
  task automatic give(input int ch, input int n);
    @(negedge clock);
    want[ch] = want[ch] + n;
    @(posedge clock);
  endtask
  // a peripheral drops its request once its last byte moved
  always @(posedge clock) begin
    if (transfer_strobe === 1'b1 && want[exec_channel] > 0) want[exec_channel] <= want[exec_channel] - 1;
  end
  always_comb begin
    for (int c = 0; c < NUM_CHANNELS; c++) channel_transfer_request[c] = want[c] > 0;
  end
  // processor lets go grant_delay + 1 cycles after the request, so both prompt and slow hand-over occur
  always @(posedge clock) begin
    if (halt_bus_request_n && stretch_bus_request_n) begin
      wait_cnt <= 0;
      bus_grant <= 1'b0;
    end else begin
      wait_cnt <= wait_cnt + 1;
      bus_grant <= wait_cnt >= grant_delay;
    end
  end
endmodule // req_partner
`default_nettype wire

// *** verification/testbench.sv ***
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import dma_prio_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  reg_req_t req = '0;
  logic [DATA_WIDTH-1:0] rdata;
  logic [NUM_CHANNELS-1:0] trq;
  logic grant, halt_n, stretch_n, ack, strobe;
  logic [1:0] exec;
  int error_cnt = 0;
  int n_checks = 0;
  logic [1:0] served [$];
  always #10 clock = ~clock;
  dma_channel_priority_status uut (.clock(clock), .rst_n(rst_n), .ce(ce), .reg_req(req), .reg_rdata(rdata),
    .channel_transfer_request(trq), .bus_grant(grant), .halt_bus_request_n(halt_n),
    .stretch_bus_request_n(stretch_n), .transfer_ack(ack), .transfer_strobe(strobe), .exec_channel(exec));
  req_partner partner (.clock(clock), .halt_bus_request_n(halt_n), .stretch_bus_request_n(stretch_n),
    .transfer_strobe(strobe), .exec_channel(exec), .channel_transfer_request(trq), .bus_grant(grant));
  // log the channel of every byte moved
  always @(posedge clock) if (strobe === 1'b1) served.push_back(exec);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // write leaves the strobe up; the next call or idle replaces it at the next edge
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    req <= '0;
    @(negedge clock);
    chk(rdata, exp);
    @(posedge clock);
  endtask
  task automatic idle(input int n);
    req <= '0;
    repeat (n) @(posedge clock);
  endtask
  task automatic arm(input int ch, input logic [15:0] ctrl, input logic [15:0] cnt, input int n);
    wr(CTRL_BASE + 4'(ch), ctrl);
    wr(COUNT_BASE + 4'(ch), cnt);
    idle(1);
    partner.give(ch, n);
  endtask
  // waits, bounded, for the expected bytes and compares their channel order
  task automatic seq(input int exp [$]);
    for (int i = 0; i < 2000 && served.size() < exp.size(); i++) @(posedge clock);
    chk(16'(served.size()), 16'(exp.size()));
    foreach (exp[i]) if (i < served.size()) chk(16'(served[i]), 16'(exp[i]));
    served.delete();
  endtask
  task automatic none_moved;
    repeat (30) @(posedge clock);
    chk(16'(served.size()), 16'h0000);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6000) @(posedge clock);
    error_cnt++;
    end_sim;
  end
  initial begin
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    rd(PRIORITY_OFFSET, 16'h0000);
    rd(CTRL_BASE, 16'h0000);
    rd(4'hF, 16'h0000);
    wr(COUNT_BASE + 4'h1, 16'h0005);
    rst_n <= 1'b0;
    idle(2);
    rst_n <= 1'b1;
    rd(COUNT_BASE + 4'h1, 16'h0005);
    wr(PRIORITY_OFFSET, 16'h000F);
    idle(1);
    partner.give(1, 1);
    none_moved;
    partner.give(1, -1);
    $display("test reset and zero flag done");
    wr(PRIORITY_OFFSET, 16'h0000);
    for (int c = 0; c < 4; c++) arm(c, 16'h0000, 16'h0002, 2);
    none_moved;
    wr(PRIORITY_OFFSET, 16'h000F);
    idle(1);
    seq({0, 1, 0, 1, 2, 3, 2, 3});
    rd(CTRL_BASE, 16'h0080);
    rd(CTRL_BASE, 16'h0000);
    $display("test fixed priority done");
    wr(PRIORITY_OFFSET, 16'h0080);
    for (int c = 0; c < 4; c++) arm(c, 16'h0000, 16'h0002, 2);
    wr(PRIORITY_OFFSET, 16'h008F);
    idle(1);
    seq({0, 1, 2, 3, 0, 1, 2, 3});
    $display("test rotating priority done");
    wr(PRIORITY_OFFSET, 16'h0004);
    partner.grant_delay = 5;
    arm(0, 16'h0000, 16'h0001, 1);
    arm(2, 16'h0001, 16'h0003, 3);
    seq({2});
    wr(PRIORITY_OFFSET, 16'h000F);
    idle(1);
    seq({2, 2, 0});
    $display("test burst hold done");
    partner.grant_delay = 1;
    arm(1, 16'h0002, 16'h0002, 0);
    arm(3, 16'h0002, 16'h0001, 0);
    partner.give(1, 2);
    partner.give(3, 1);
    seq({1, 1, 3});
    $display("test clock stretch done");
    arm(0, 16'h0000, 16'h0004, 0);
    wr(COUNT_BASE, 16'h0000);
    idle(1);
    partner.give(0, 1);
    none_moved;
    $display("test zero write done");
    end_sim;
  end
endmodule // testbench
`default_nettype wire
